// >>> core/ifs_pkg.sv
//------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------
// Notes on behaviour
// - Clocked serial format raises the interrupt flag at the eighth clock rise.
// - Serial format raises the interrupt flag on a detected start condition.
// - Setting transmit-empty or receive-full also raises the interrupt flag.
// - Interrupt flag clears by writing zero after reading it as one.
// - Transfer controller data register access may clear the interrupt flag.
// - Slave data ends after address or general call match give no start request.
// - At transfer count end, keep interrupt and start request; clear buffer flags.
// - Start request is raised only in qualifying states, not with every buffer flag.
// - Interrupt and start request may stand without any buffer flag set.
// - Each interrupt source in bus format has its own status flag.
// - Master transmit data register write clears transmit-empty only.
// - Master receive data register read clears receive-full only.
// - Bus-format master raises the interrupt flag at the ninth clock rise.
// - Slave stop in mid frame sets the error halt flag.
package ifs_pkg;
    // APB register byte offsets.
    localparam logic [7:0] IFS_OFF_CTRL = 8'h00;
    localparam logic [7:0] IFS_OFF_FLAGS = 8'h04;
    localparam logic [7:0] IFS_OFF_DATA = 8'h08;
    localparam logic [7:0] IFS_OFF_ISTAT = 8'h0C;
    localparam logic [7:0] IFS_OFF_IEN = 8'h10;
    localparam logic [7:0] IFS_OFF_ICLR = 8'h14;
    localparam logic [7:0] IFS_OFF_XFER = 8'h18;
    // Control register bit positions.
    localparam int IFS_C_SERIAL = 0;
    localparam int IFS_C_MASTER = 1;
    localparam int IFS_C_TRANSMIT = 2;
    localparam int IFS_C_ACK_CHECK_ENABLE = 3;
    localparam int IFS_C_DTC_CLR = 4;
    // Flag register bit positions.
    localparam int IFS_F_IRQ = 0;
    localparam int IFS_F_TXE = 1;
    localparam int IFS_F_RXF = 2;
    localparam int IFS_F_REQ = 3;
    localparam int IFS_F_MST = 4;
    localparam int IFS_F_TRS = 5;
    localparam int IFS_F_BUS_BUSY_FLAG = 6;
    localparam int IFS_F_ERROR_HALT_FLAG = 7;
    localparam int IFS_F_STOP = 8;
    localparam int IFS_F_AL = 9;
    localparam int IFS_F_AAS = 10;
    localparam int IFS_F_ADZ = 11;
    localparam int IFS_F_RECEIVED_ACK_BIT = 12;
    localparam int IFS_NFLAG = 13;
    // Interrupt status event bits.
    localparam int IFS_E_IRQ = 0;
    localparam int IFS_E_ERROR_HALT_FLAG = 1;
    localparam int IFS_E_AL = 2;
    localparam int IFS_E_STOP = 3;
    localparam int IFS_NEV = 4;
    // Clock counts per frame.
    localparam logic [3:0] IFS_SER_BITS = 4'h8;
    localparam logic [3:0] IFS_BUS_BITS = 4'h9;
    localparam logic [7:0] IFS_ADDR_RESET = 8'h00;
    typedef enum logic [2:0] {
        IFS_IDLE = 3'b001,
        IFS_ADDR = 3'b010,
        IFS_DATA = 3'b100
    } ifs_state_t;
endpackage

// >>> core/ifs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for one pin level.
module ifs_sync (
    input wire logic clk_sys, // System clock.
    input wire logic reset, // Synchronous reset.
    input wire logic d, // Asynchronous level.
    output logic q // Synchronised level.
);
    logic s1_r;
    logic s1_nxt;
    logic q_nxt;

    // The first flop feeds only the second.
    always_comb
    begin
        s1_nxt = d;
        q_nxt = s1_r;
    end

    // Both stages idle high like the bus lines.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_r <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            s1_r <= s1_nxt;
            q <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> core/ifs_cond.sv
`timescale 1ns/10ps
`default_nettype none
// Edge and bus-condition detector on synchronised lines.
module ifs_cond (
    input wire logic clk_sys, // System clock.
    input wire logic reset, // Synchronous reset.
    input wire logic scl, // Synchronised clock line.
    input wire logic sda, // Synchronised data line.
    output logic scl_rise, // Clock rise pulse.
    output logic start_det, // Start condition pulse.
    output logic stop_det // Stop condition pulse.
);
    logic scl_d_r;
    logic sda_d_r;

    // Start is data falling with clock high, stop is data rising.
    always_comb
    begin
        scl_rise = scl & ~scl_d_r;
        start_det = scl & scl_d_r & sda_d_r & ~sda;
        stop_det = scl & scl_d_r & ~sda_d_r & sda;
    end

    // Previous line levels.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end
endmodule
`default_nettype wire

// >>> core/ifs_flags.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Status flag and interrupt request logic of a two-wire bus interface.
module ifs_flags (
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic reset, // Synchronous active-high reset.
    input wire logic [7:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic scl_in, // Clock line level.
    input wire logic sda_in, // Data line level.
    input wire logic dtc_access, // Transfer controller data access pulse.
    input wire logic dtc_last, // Last controller transfer pulse.
    input wire logic addr_match, // Own address matched in first frame.
    input wire logic gcall_match, // General call matched in first frame.
    input wire logic arb_lost, // Arbitration lost pulse.
    input wire logic ack_in, // Received acknowledge bit, 1 is no-ack.
    input wire logic rw_bit, // Received read-write bit.
    output logic irq, // Level interrupt.
    output logic transfer_ctrl_start_request, // Controller start request.
    output logic [7:0] bus_data_register // Last received byte.
);
    import ifs_pkg::*;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic start_det;
    logic stop_det;

    ifs_sync u_sync_scl (
        .clk_sys(clk_sys),
        .reset(reset),
        .d(scl_in),
        .q(scl_s)
    );

    ifs_sync u_sync_sda (
        .clk_sys(clk_sys),
        .reset(reset),
        .d(sda_in),
        .q(sda_s)
    );

    ifs_cond u_cond (
        .clk_sys(clk_sys),
        .reset(reset),
        .scl(scl_s),
        .sda(sda_s),
        .scl_rise(scl_rise),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    logic [4:0] ctrl_r;
    logic [4:0] ctrl_nxt;
    logic [IFS_NFLAG-1:0] fl_r;
    logic [IFS_NFLAG-1:0] fl_nxt;
    logic irq_seen_r;
    logic irq_seen_nxt;
    logic [IFS_NEV-1:0] ist_r;
    logic [IFS_NEV-1:0] ist_nxt;
    logic [IFS_NEV-1:0] ien_r;
    logic [IFS_NEV-1:0] ien_nxt;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] rxbuf_r;
    logic [7:0] rxbuf_nxt;
    logic [7:0] txbuf_r;
    logic [7:0] txbuf_nxt;
    logic slave_hold_r;
    logic slave_hold_nxt;
    ifs_state_t st_r;
    ifs_state_t st_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt;
    logic pslverr_nxt;
    logic irq_nxt;
    logic req_out_nxt;

    logic acc;
    logic wr;
    logic rd;
    logic frame_end;
    logic [3:0] frame_len;
    logic [IFS_NEV-1:0] ev;
    // Decoded register strobes.
    logic wr_ctrl;
    logic wr_flags;
    logic rd_flags;
    logic wr_data;
    logic rd_data;
    logic wr_ien;
    logic wr_iclr;

    // APB access completes in the second access-phase cycle once pready rises.
    always_comb
    begin
        acc = psel & penable & ~pready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        frame_len = ctrl_r[IFS_C_SERIAL] ? IFS_SER_BITS : IFS_BUS_BITS;
        frame_end = scl_rise & (st_r != IFS_IDLE) & (bitcnt_r == frame_len - 4'h1);
    end

    // One strobe per register access keeps the flag logic readable.
    always_comb
    begin
        wr_ctrl = wr & (paddr == IFS_OFF_CTRL);
        wr_flags = wr & (paddr == IFS_OFF_FLAGS);
        rd_flags = rd & (paddr == IFS_OFF_FLAGS);
        wr_data = wr & (paddr == IFS_OFF_DATA);
        rd_data = rd & (paddr == IFS_OFF_DATA);
        wr_ien = wr & (paddr == IFS_OFF_IEN);
        wr_iclr = wr & (paddr == IFS_OFF_ICLR);
    end

    //--------------------------------------------------------------------
    // Flag and transfer logic
    //--------------------------------------------------------------------
    // Computes every flag from bus events and software access.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        fl_nxt = fl_r;
        irq_seen_nxt = irq_seen_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        rxbuf_nxt = rxbuf_r;
        txbuf_nxt = txbuf_r;
        slave_hold_nxt = slave_hold_r;
        st_nxt = st_r;
        ev = '0;
        if (wr_ctrl)
        begin
            ctrl_nxt = pwdata[4:0];
            fl_nxt[IFS_F_MST] = pwdata[IFS_C_MASTER];
            fl_nxt[IFS_F_TRS] = pwdata[IFS_C_TRANSMIT];
        end
        // Software clears by writing zero after reading one; a one keeps it.
        if (rd_flags)
            irq_seen_nxt = fl_r[IFS_F_IRQ];
        if (wr_flags && irq_seen_r && !pwdata[IFS_F_IRQ])
        begin
            fl_nxt[IFS_F_IRQ] = 1'b0;
            fl_nxt[IFS_F_ERROR_HALT_FLAG] = 1'b0;
            fl_nxt[IFS_F_STOP] = 1'b0;
            fl_nxt[IFS_F_REQ] = 1'b0;
            irq_seen_nxt = 1'b0;
        end
        // Controller access clears the flag automatically when enabled, except with the last transfer pulse.
        if (dtc_access && ctrl_r[IFS_C_DTC_CLR] && !dtc_last)
            fl_nxt[IFS_F_IRQ] = 1'b0;
        // Data register write and read touch one buffer flag only.
        if (wr_data)
        begin
            txbuf_nxt = pwdata[7:0];
            fl_nxt[IFS_F_TXE] = 1'b0;
        end
        if (rd_data || dtc_access)
            fl_nxt[IFS_F_RXF] = 1'b0;
        if (dtc_access && fl_r[IFS_F_TRS])
            fl_nxt[IFS_F_TXE] = 1'b0;
        // Last controller transfer drops buffer flags and keeps requests.
        if (dtc_last)
        begin
            fl_nxt[IFS_F_TXE] = 1'b0;
            fl_nxt[IFS_F_RXF] = 1'b0;
        end
        // Bit counting on each clock rise in a frame; shifting on the first eight only.
        if (scl_rise && st_r != IFS_IDLE)
        begin
            bitcnt_nxt = bitcnt_r + 4'h1;
            if (bitcnt_r < IFS_SER_BITS)
                shift_nxt = {shift_r[6:0], sda_s};
        end
        if (frame_end)
        begin
            bitcnt_nxt = '0;
            fl_nxt[IFS_F_IRQ] = 1'b1;
            if (!ctrl_r[IFS_C_SERIAL] && ctrl_r[IFS_C_ACK_CHECK_ENABLE] && sda_s)
                fl_nxt[IFS_F_RECEIVED_ACK_BIT] = 1'b1;
            if (st_r == IFS_ADDR)
            begin
                st_nxt = IFS_DATA;
                if (addr_match || gcall_match)
                begin
                    fl_nxt[IFS_F_AAS] = 1'b1;
                    fl_nxt[IFS_F_ADZ] = gcall_match;
                    fl_nxt[IFS_F_TRS] = rw_bit & ~gcall_match;
                    slave_hold_nxt = ~fl_r[IFS_F_MST];
                end
            end
            // Buffer moves raise the flags and, where qualified, the request.
            // A matched slave address frame already withholds the request.
            if (fl_r[IFS_F_TRS])
            begin
                shift_nxt = txbuf_r;
                fl_nxt[IFS_F_TXE] = 1'b1;
                if (!slave_hold_nxt)
                    fl_nxt[IFS_F_REQ] = 1'b1;
            end
            else
            begin
                // The shifter already holds this clock's bit, so a short serial frame is complete.
                rxbuf_nxt = shift_nxt;
                fl_nxt[IFS_F_RXF] = 1'b1;
                if (!slave_hold_nxt)
                    fl_nxt[IFS_F_REQ] = 1'b1;
            end
        end
        // Lost arbitration hands the bus back but leaves it busy.
        if (arb_lost && fl_r[IFS_F_MST])
        begin
            fl_nxt[IFS_F_MST] = 1'b0;
            fl_nxt[IFS_F_TRS] = 1'b0;
            fl_nxt[IFS_F_AL] = 1'b1;
            ev[IFS_E_AL] = 1'b1;
        end
        // A start opens a frame and marks the bus busy.
        if (start_det)
        begin
            st_nxt = ctrl_r[IFS_C_SERIAL] ? IFS_DATA : IFS_ADDR;
            bitcnt_nxt = '0;
            slave_hold_nxt = 1'b0;
            fl_nxt[IFS_F_BUS_BUSY_FLAG] = 1'b1;
            fl_nxt[IFS_F_AAS] = 1'b0;
            fl_nxt[IFS_F_ADZ] = 1'b0;
            fl_nxt[IFS_F_IRQ] = ctrl_r[IFS_C_SERIAL] | fl_r[IFS_F_TRS] | fl_r[IFS_F_IRQ];
            if (fl_r[IFS_F_TRS])
            begin
                fl_nxt[IFS_F_TXE] = 1'b1;
                fl_nxt[IFS_F_REQ] = fl_r[IFS_F_MST] | fl_r[IFS_F_REQ];
            end
        end
        // Stop ends the bus; flags may stand without buffer flags.
        if (stop_det)
        begin
            st_nxt = IFS_IDLE;
            slave_hold_nxt = 1'b0;
            fl_nxt[IFS_F_BUS_BUSY_FLAG] = 1'b0;
            fl_nxt[IFS_F_TXE] = 1'b0;
            fl_nxt[IFS_F_IRQ] = 1'b1;
            fl_nxt[IFS_F_REQ] = 1'b1;
            // A slave stop inside a frame is an error halt, otherwise a clean stop.
            if (!fl_r[IFS_F_MST] && bitcnt_r != 4'h0)
                fl_nxt[IFS_F_ERROR_HALT_FLAG] = 1'b1;
            else
                fl_nxt[IFS_F_STOP] = 1'b1;
        end
        // Rising flags feed the sticky status events.
        ev[IFS_E_IRQ] = fl_nxt[IFS_F_IRQ] & ~fl_r[IFS_F_IRQ];
        ev[IFS_E_ERROR_HALT_FLAG] = fl_nxt[IFS_F_ERROR_HALT_FLAG] & ~fl_r[IFS_F_ERROR_HALT_FLAG];
        ev[IFS_E_STOP] = fl_nxt[IFS_F_STOP] & ~fl_r[IFS_F_STOP];
    end

    //--------------------------------------------------------------------
    // Interrupt and APB answer
    //--------------------------------------------------------------------
    // Sticky events win over a clear in the same cycle.
    always_comb
    begin
        ist_nxt = ist_r;
        ien_nxt = ien_r;
        if (wr_iclr)
            ist_nxt = ist_r & ~pwdata[IFS_NEV-1:0];
        ist_nxt = ist_nxt | ev;
        if (wr_ien)
            ien_nxt = pwdata[IFS_NEV-1:0];
        irq_nxt = |(ist_nxt & ien_nxt);
        req_out_nxt = fl_nxt[IFS_F_REQ];
        pready_nxt = acc;
        pslverr_nxt = 1'b0;
        prdata_nxt = '0;
        if (acc)
        begin
            case (paddr)
                IFS_OFF_CTRL: prdata_nxt = {27'h0, ctrl_r};
                IFS_OFF_FLAGS: prdata_nxt = {19'h0, fl_r};
                IFS_OFF_DATA: prdata_nxt = {24'h0, rxbuf_r};
                IFS_OFF_ISTAT: prdata_nxt = {28'h0, ist_r};
                IFS_OFF_IEN: prdata_nxt = {28'h0, ien_r};
                IFS_OFF_ICLR: prdata_nxt = '0;
                IFS_OFF_XFER: prdata_nxt = {20'h0, bitcnt_r, shift_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    // Registers all state.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl_r <= '0;
            fl_r <= '0;
            irq_seen_r <= 1'b0;
            ist_r <= '0;
            ien_r <= '0;
            bitcnt_r <= '0;
            shift_r <= '0;
            rxbuf_r <= IFS_ADDR_RESET;
            txbuf_r <= '0;
            slave_hold_r <= 1'b0;
            st_r <= IFS_IDLE;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            transfer_ctrl_start_request <= 1'b0;
            bus_data_register <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            fl_r <= fl_nxt;
            irq_seen_r <= irq_seen_nxt;
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            rxbuf_r <= rxbuf_nxt;
            txbuf_r <= txbuf_nxt;
            slave_hold_r <= slave_hold_nxt;
            st_r <= st_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            irq <= irq_nxt;
            transfer_ctrl_start_request <= req_out_nxt;
            bus_data_register <= rxbuf_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> dv/ifs_flags_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the flag block, bound onto every instance.
module ifs_flags_properties (
    input wire logic clk_sys, // System clock.
    input wire logic reset, // Synchronous reset.
    input wire logic [7:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic dtc_last, // Last controller transfer.
    input wire logic irq, // Level interrupt.
    input wire logic transfer_ctrl_start_request // Controller start request.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    //--------------------------------------------------------------
    // Register bus
    //--------------------------------------------------------------
    // The answer comes one cycle after the access is taken and lasts one cycle.
    property p_ready_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("ready late");
    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held");
    property p_ready_held;
        pready |-> psel && penable;
    endproperty
    a_ready_held: assert property (p_ready_held) else $error("ready without access");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_unmapped;
        pready && paddr > 8'h18 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_mapped;
        pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    //--------------------------------------------------------------
    // Flags
    //--------------------------------------------------------------
    // Reset drops irq, pready and the start request one edge later.
    property p_reset_quiet;
        @(posedge clk_sys) disable iff (1'b0) reset |=> !irq && !pready && !transfer_ctrl_start_request;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_req_keep_last;
        transfer_ctrl_start_request && dtc_last |=> transfer_ctrl_start_request [*2];
    endproperty
    a_req_keep_last: assert property (p_req_keep_last) else $error("request lost at last transfer");
    property p_req_write1;
        psel && penable && pwrite && paddr == 8'h04 && pwdata[0] && transfer_ctrl_start_request
            |=> transfer_ctrl_start_request [*2];
    endproperty
    a_req_write1: assert property (p_req_write1) else $error("writing one cleared request");
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_req: cover property ($rose(transfer_ctrl_start_request));
endmodule
`default_nettype wire

// >>> dv/ifs_bus_peer.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side bus party on pulled-up lines; its clock stands still between frames.
module ifs_bus_peer (
    output logic scl, // Clock line level.
    output logic sda // Data line level.
);
    localparam int HALF = 160;
    // Lines rest high through the pull-ups.
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Data falls while the clock is high, then the clock falls.
    task automatic send_start();
        #7;
        sda = 1'b0;
        #HALF;
        scl = 1'b0;
        #40;
    endtask
    // Bits go out first to last; data only moves while the clock is low.
    task automatic send_bits(input int n, input logic [7:0] v);
        for (int i = 0; i < n; i++)
        begin
            #40;
            sda = (i < 8) ? v[7 - i] : 1'b0;
            #(HALF - 40);
            scl = 1'b1;
            #HALF;
            scl = 1'b0;
        end
    endtask
    // Data rises while the clock is high to close the frame.
    task automatic send_stop();
        #40;
        sda = 1'b0;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda = 1'b1;
        #HALF;
    endtask
endmodule
`default_nettype wire

// >>> dv/ifs_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
bind ifs_flags ifs_flags_properties u_props (.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dtc_last(dtc_last), .irq(irq), .transfer_ctrl_start_request(transfer_ctrl_start_request));
// Self-checking bench of the flag block.
module ifs_flags_test;
    import ifs_pkg::*;
    logic clk_sys = 1'b0;
    logic reset, psel, penable, pwrite, dtc_access, dtc_last, addr_match, gcall_match, arb_lost, ack_in, rw_bit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, errv, irq, transfer_ctrl_start_request, scl, sda;
    logic [7:0] bus_data_register, b;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] byte_q[$];
    always #20 clk_sys = ~clk_sys;
    ifs_bus_peer peer (.scl(scl), .sda(sda));
    ifs_flags dut (.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
        .sda_in(sda), .dtc_access(dtc_access), .dtc_last(dtc_last), .addr_match(addr_match),
        .gcall_match(gcall_match), .arb_lost(arb_lost), .ack_in(ack_in), .rw_bit(rw_bit), .irq(irq),
        .transfer_ctrl_start_request(transfer_ctrl_start_request), .bus_data_register(bus_data_register));
    //--------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------
    // Prints the verdict and ends the run.
    task automatic test_done();
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Compares one value and reports a difference.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer; the request holds until ready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reads the flag register and compares the bits under the mask.
    task automatic flags(input string name, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, IFS_OFF_FLAGS, 32'h0);
        chk(name, exp, rdv & mask);
    endtask
    // Software clearing: read, write zero, then drop the event bits.
    task automatic clr_irq();
        apb(1'b0, IFS_OFF_FLAGS, 32'h0);
        apb(1'b1, IFS_OFF_FLAGS, 32'h0);
        apb(1'b1, IFS_OFF_ICLR, 32'h0000000F);
    endtask
    // Cycle ceiling that cuts a hang short.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            test_done();
        end
    end
    //--------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------
    // Resets the block, then walks serial, master and slave cases.
    initial
    begin
        {reset, psel, penable, pwrite, dtc_access, dtc_last, arb_lost, ack_in} = 8'h80;
        {addr_match, gcall_match, rw_bit, paddr, pwdata} = '0;
        void'($urandom(32'h5131));
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        flags("flags_reset", 32'h00001FFF, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, errv});
        // Serial format: start and the eighth clock each raise the flag.
        apb(1'b1, IFS_OFF_CTRL, 32'h00000001);
        peer.send_start();
        flags("ser_start", 32'h1, 32'h1);
        apb(1'b1, IFS_OFF_IEN, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, IFS_OFF_IEN, 32'h00000001);
        apb(1'b0, IFS_OFF_ISTAT, 32'h0);
        chk("irq_enabled", 32'h1, {31'h0, irq});
        clr_irq();
        apb(1'b0, IFS_OFF_ISTAT, 32'h0);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        b = 8'($urandom());
        peer.send_bits(8, b);
        apb(1'b1, IFS_OFF_FLAGS, 32'h0);
        flags("no_read_clear", 32'h1, 32'h1);
        apb(1'b1, IFS_OFF_FLAGS, 32'h00000001);
        flags("ser_eighth", 32'h1, 32'h1);
        apb(1'b1, IFS_OFF_FLAGS, 32'h0);
        flags("read_clear", 32'h1, 32'h0);
        peer.send_stop();
        // Master receive: flag at the ninth clock, data read clears full.
        apb(1'b1, IFS_OFF_CTRL, 32'h00000012);
        peer.send_start();
        flags("mr_busy", 32'h40, 32'h40);
        clr_irq();
        b = 8'($urandom());
        byte_q.push_back(b);
        peer.send_bits(8, b);
        flags("mr_eighth", 32'h1, 32'h0);
        peer.send_bits(1, 8'h00);
        flags("mr_ninth", 32'h17, 32'h15);
        chk("mr_req", 32'h1, {31'h0, transfer_ctrl_start_request});
        apb(1'b0, IFS_OFF_DATA, 32'h0);
        chk("rx_data", {24'h0, byte_q.pop_front()}, rdv);
        flags("mr_read", 32'h5D, 32'h59);
        b = 8'($urandom());
        byte_q.push_back(b);
        peer.send_bits(9, b);
        @(posedge clk_sys);
        dtc_access <= 1'b1;
        @(posedge clk_sys);
        dtc_access <= 1'b0;
        flags("dtc_clear", 32'h5, 32'h0);
        chk("rx_byte", {24'h0, byte_q.pop_front()}, {24'h0, bus_data_register});
        b = 8'($urandom());
        byte_q.push_back(b);
        peer.send_bits(9, b);
        @(posedge clk_sys);
        dtc_last <= 1'b1;
        @(posedge clk_sys);
        dtc_last <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("last_req", 32'h1, {31'h0, transfer_ctrl_start_request});
        flags("last_flags", 32'hF, 32'h9);
        chk("rx_byte", {24'h0, byte_q.pop_front()}, {24'h0, bus_data_register});
        peer.send_stop();
        flags("stop_free", 32'h4F, 32'h9);
        // Master transmit: start, data write, then lost arbitration.
        apb(1'b1, IFS_OFF_CTRL, 32'h00000006);
        peer.send_start();
        flags("mt_start", 32'h42, 32'h42);
        apb(1'b1, IFS_OFF_DATA, {24'h0, 8'($urandom())});
        flags("mt_write", 32'h72, 32'h70);
        arb_lost <= 1'b1;
        @(posedge clk_sys);
        arb_lost <= 1'b0;
        flags("arb_lost", 32'h270, 32'h240);
        peer.send_stop();
        // Slave mode: no request after an address match; a stop in mid frame halts.
        clr_irq();
        apb(1'b1, IFS_OFF_CTRL, 32'h0);
        addr_match <= 1'b1;
        peer.send_start();
        peer.send_bits(9, 8'($urandom()));
        flags("sl_addr", 32'h40C, 32'h404);
        peer.send_bits(9, 8'($urandom()));
        flags("sl_data", 32'h9, 32'h1);
        peer.send_bits(4, 8'($urandom()));
        peer.send_stop();
        flags("err_halt", 32'h80, 32'h80);
        apb(1'b0, IFS_OFF_ISTAT, 32'h0);
        chk("err_event", 32'h2, rdv & 32'h2);
        test_done();
    end
endmodule
`default_nettype wire
